// ---- verilog/bsr_pkg.sv ----
// ****************************************************************
// Shared constants for the buck set-point register bank
// ****************************************************************
package bsr_pkg;

  // Two rails: index 0 is rail A, index 1 is rail B
  localparam int NUM_RAILS = 2;
  localparam int RAIL_A = 0;
  localparam int RAIL_B = 1;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_RAIL_A_NORMAL_SETPOINT = 8'h3C;
  localparam logic [7:0] ADDR_RAIL_A_STANDBY_SETPOINT = 8'h3D;
  localparam logic [7:0] ADDR_RAIL_A_SLEEP_SETPOINT = 8'h3E;
  localparam logic [7:0] ADDR_RAIL_A_SWITCHING_MODE = 8'h3F;
  localparam logic [7:0] ADDR_RAIL_A_CONFIG = 8'h40;
  localparam logic [7:0] ADDR_RAIL_B_NORMAL_SETPOINT = 8'h43;
  localparam logic [7:0] ADDR_RAIL_B_STANDBY_SETPOINT = 8'h44;
  localparam logic [7:0] ADDR_RAIL_B_SLEEP_SETPOINT = 8'h45;
  localparam logic [7:0] ADDR_RAIL_B_SWITCHING_MODE = 8'h46;
  localparam logic [7:0] ADDR_RAIL_B_CONFIG = 8'h47;

  // Slot of each register inside a rail's block of five
  localparam logic [7:0] SLOT_NORMAL = 8'h00;
  localparam logic [7:0] SLOT_STANDBY = 8'h01;
  localparam logic [7:0] SLOT_SLEEP = 8'h02;
  localparam logic [7:0] SLOT_MODE = 8'h03;
  localparam logic [7:0] SLOT_CONFIG = 8'h04;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int LEVEL_MSB = 5;
  localparam int RANGE_BIT = 6;
  localparam logic [7:0] MASK_MODE = 8'h2F;
  localparam logic [7:0] MASK_CONFIG = 8'hFF;
  localparam logic [5:0] RESET_LEVEL = 6'h00;
  localparam logic [7:0] RESET_MODE = 8'h00;
  localparam logic [7:0] RESET_CONFIG = 8'h00;
  localparam logic RESET_RANGE = 1'b0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ****************************************************************
  // Set-point code table
  // ****************************************************************
  localparam logic [6:0] CODE_LOW_MAX = 7'h3F;   // 1.975 V
  localparam logic [6:0] CODE_HIGH_MAX = 7'h72;  // 3.300 V
  localparam logic [11:0] LOW_BASE_MV = 12'h190;   // 400 mV
  localparam logic [11:0] LOW_STEP_MV = 12'h019;   // 25 mV
  localparam logic [11:0] HIGH_BASE_MV = 12'h320;  // 800 mV
  localparam logic [11:0] HIGH_STEP_MV = 12'h032;  // 50 mV

  // Operating state of the device as seen by the rails
  typedef enum logic [1:0] {OP_NORMAL, OP_STANDBY, OP_SLEEP} bsr_opstate_t;

endpackage

// ---- verilog/bsr_level_decode.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Set-point code to millivolt decoder
// ****************************************************************
module bsr_level_decode
  import bsr_pkg::*;
(
  input wire logic [6:0] code,
  output logic [11:0] levelMv,
  output logic codeValid
);

  // Range bit splits the table in two halves
  wire highRange = code[RANGE_BIT];
  // Step count within the range
  wire [11:0] stepCount = {6'h00, code[LEVEL_MSB:0]};
  // Low range: 25 mV per step from 400 mV
  wire [11:0] lowMv = LOW_BASE_MV + 12'(stepCount * LOW_STEP_MV);
  // High range: 50 mV per step from 800 mV
  wire [11:0] highMv = HIGH_BASE_MV + 12'(stepCount * HIGH_STEP_MV);

  // Top low code is 1.975 V; all 64 low codes are legal
  assign levelMv = highRange ? highMv : lowMv;
  // Codes past 3.300 V are reserved, never a level
  assign codeValid = !highRange || (code <= CODE_HIGH_MAX);

endmodule

// ---- verilog/bsr_setpoint_bank.sv ----
`timescale 1ns/1ns
// How it works
// - Low-range codes end at 1.975 V
// - High codes above 3.300 V are reserved
// - Rail A registers at 0x3C through 0x40
// - Rail B registers at 0x43 through 0x47
// - Normal field sets rail output level
// - Range bit read-only, set by configuration
// - Standby bit six copies the range bit
// - Sleep bit six copies the range bit
// - Standby state applies standby set point
// - Sleep state applies sleep set point
// - Low range: 25 mV steps from 0.40 V
// - High range: 50 mV steps from 0.80 V
module bsr_setpoint_bank
  import bsr_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic cfgLoad,
  input wire logic [1:0] cfgRange,
  input wire bsr_opstate_t opState,
  input wire logic singlePhase,
  output logic [7:0] regRdData,
  output logic regAck,
  output logic [6:0] railALevelCode,
  output logic [11:0] railALevelMv,
  output logic railACodeValid,
  output logic [7:0] railAModeOut,
  output logic [7:0] railAConfigOut,
  output logic [6:0] railBLevelCode,
  output logic [11:0] railBLevelMv,
  output logic railBCodeValid,
  output logic railBActive,
  output logic [7:0] railBModeOut,
  output logic [7:0] railBConfigOut
);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Base of each rail's block; used by every register decode
  function automatic logic [7:0] railBase(input int rail);
    railBase = (rail == RAIL_B) ? ADDR_RAIL_B_NORMAL_SETPOINT
                                : ADDR_RAIL_A_NORMAL_SETPOINT;
  endfunction

  // True when an address selects one slot of one rail
  function automatic logic isReg(input logic [7:0] addr, input int rail,
                                 input logic [7:0] slot);
    isReg = (addr == 8'(railBase(rail) + slot));
  endfunction

  // ****************************************************************
  // Register storage, one set per rail
  // ****************************************************************
  logic [5:0] normLvl_reg [NUM_RAILS];   // Normal set point field
  logic [5:0] stbyLvl_reg [NUM_RAILS];   // Standby set point field
  logic [5:0] sleepLvl_reg [NUM_RAILS];  // Sleep set point field
  logic [7:0] mode_reg [NUM_RAILS];      // Switching mode register
  logic [7:0] config_reg [NUM_RAILS];    // Rail configuration register
  logic rangeSel_reg [NUM_RAILS];        // Range bit, one per rail

  // Decoded hits
  logic [NUM_RAILS-1:0] hitNormal;
  logic [NUM_RAILS-1:0] hitStandby;
  logic [NUM_RAILS-1:0] hitSleep;
  logic [NUM_RAILS-1:0] hitMode;
  logic [NUM_RAILS-1:0] hitConfig;
  logic [7:0] rdRail [NUM_RAILS];        // Per-rail read value
  logic [6:0] selCode [NUM_RAILS];       // Code chosen by state
  logic [11:0] decMv [NUM_RAILS];        // Decoded millivolts
  logic [NUM_RAILS-1:0] decValid;        // Decoded code is legal
  logic [NUM_RAILS-1:0] railOn;          // Rail drives its own output

  // Output flops
  logic [6:0] levelCode_reg [NUM_RAILS];
  logic [11:0] levelMv_reg [NUM_RAILS];
  logic [NUM_RAILS-1:0] codeValid_reg;
  logic railBActive_reg;
  logic [7:0] regRdData_reg;
  logic regAck_reg;

  genvar r;
  generate
    for (r = 0; r < NUM_RAILS; r++) begin : gRail
      // ****************************************************************
      // Decode of this rail's five registers
      // ****************************************************************
      assign hitNormal[r] = isReg(regAddr, r, SLOT_NORMAL);
      assign hitStandby[r] = isReg(regAddr, r, SLOT_STANDBY);
      assign hitSleep[r] = isReg(regAddr, r, SLOT_SLEEP);
      assign hitMode[r] = isReg(regAddr, r, SLOT_MODE);
      assign hitConfig[r] = isReg(regAddr, r, SLOT_CONFIG);

      // Write path: only bits 5:0 of a set point take the write data.
      // Bit 6 and bit 7 are never stored from the bus, so no host
      // write can move the rail across ranges.
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          normLvl_reg[r] <= RESET_LEVEL;
          stbyLvl_reg[r] <= RESET_LEVEL;
          sleepLvl_reg[r] <= RESET_LEVEL;
          mode_reg[r] <= RESET_MODE;
          config_reg[r] <= RESET_CONFIG;
        end else if (regWrEn) begin
          if (hitNormal[r]) begin
            normLvl_reg[r] <= regWrData[LEVEL_MSB:0];
          end
          if (hitStandby[r]) begin
            stbyLvl_reg[r] <= regWrData[LEVEL_MSB:0];
          end
          if (hitSleep[r]) begin
            sleepLvl_reg[r] <= regWrData[LEVEL_MSB:0];
          end
          if (hitMode[r]) begin
            mode_reg[r] <= regWrData & MASK_MODE;
          end
          if (hitConfig[r]) begin
            config_reg[r] <= regWrData & MASK_CONFIG;
          end
        end
      end

      // Range bit moves only on a configuration load
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          rangeSel_reg[r] <= RESET_RANGE;
        end else if (cfgLoad) begin
          rangeSel_reg[r] <= cfgRange[r];
        end
      end

      // Read value; standby and sleep show the shared range bit so
      // all three states report the same range. Bit 7 is zero.
      assign rdRail[r] =
        hitNormal[r]  ? {1'b0, rangeSel_reg[r], normLvl_reg[r]} :
        hitStandby[r] ? {1'b0, rangeSel_reg[r], stbyLvl_reg[r]} :
        hitSleep[r]   ? {1'b0, rangeSel_reg[r], sleepLvl_reg[r]} :
        hitMode[r]    ? mode_reg[r] :
        hitConfig[r]  ? config_reg[r] : READ_ZERO;

      // ****************************************************************
      // Level selection by operating state
      // ****************************************************************
      assign selCode[r] =
        (opState == OP_STANDBY) ? {rangeSel_reg[r], stbyLvl_reg[r]} :
        (opState == OP_SLEEP) ? {rangeSel_reg[r], sleepLvl_reg[r]} :
        {rangeSel_reg[r], normLvl_reg[r]};

      // Rail B only drives its own output as an independent rail
      assign railOn[r] = (r == RAIL_A) || !singlePhase;

      bsr_level_decode uDecode (
        .code(selCode[r]),
        .levelMv(decMv[r]),
        .codeValid(decValid[r])
      );

      // Outputs to the regulator. A reserved code never reaches the
      // millivolt output: the last legal level is held instead.
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          levelCode_reg[r] <= {RESET_RANGE, RESET_LEVEL};
          levelMv_reg[r] <= LOW_BASE_MV;
          codeValid_reg[r] <= 1'b1;
        end else if (!railOn[r]) begin
          levelCode_reg[r] <= {RESET_RANGE, RESET_LEVEL};
          levelMv_reg[r] <= LOW_BASE_MV;
          codeValid_reg[r] <= 1'b0;
        end else begin
          levelCode_reg[r] <= selCode[r];
          codeValid_reg[r] <= decValid[r];
          if (decValid[r]) begin
            levelMv_reg[r] <= decMv[r];
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read port and acknowledge
  // ****************************************************************
  wire addrMapped = |{hitNormal, hitStandby, hitSleep, hitMode, hitConfig};
  wire [7:0] rdDataNext = rdRail[RAIL_A] | rdRail[RAIL_B];

  // Read data is held until the next read; unmapped reads give zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      regRdData_reg <= READ_ZERO;
      regAck_reg <= 1'b0;
      railBActive_reg <= 1'b0;
    end else begin
      if (regRdEn) begin
        regRdData_reg <= rdDataNext;
      end
      regAck_reg <= (regRdEn || regWrEn) && addrMapped;
      railBActive_reg <= !singlePhase;
    end
  end

  // ****************************************************************
  // Output wiring, all straight from flops
  // ****************************************************************
  assign regRdData = regRdData_reg;
  assign regAck = regAck_reg;
  assign railALevelCode = levelCode_reg[RAIL_A];
  assign railALevelMv = levelMv_reg[RAIL_A];
  assign railACodeValid = codeValid_reg[RAIL_A];
  assign railAModeOut = mode_reg[RAIL_A];
  assign railAConfigOut = config_reg[RAIL_A];
  assign railBLevelCode = levelCode_reg[RAIL_B];
  assign railBLevelMv = levelMv_reg[RAIL_B];
  assign railBCodeValid = codeValid_reg[RAIL_B];
  assign railBActive = railBActive_reg;
  assign railBModeOut = mode_reg[RAIL_B];
  assign railBConfigOut = config_reg[RAIL_B];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cbMain @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Write of a value to an address, then a read of the same address
  sequence wrThenRd(logic [7:0] addr, logic [7:0] data);
    (regWrEn && !regRdEn && regAddr == addr && regWrData == data)
      ##1 (regRdEn && !regWrEn && regAddr == addr && !cfgLoad);
  endsequence

  // Rail A normal set point round trip
  rail_a_decode_a: assert property (
    wrThenRd(ADDR_RAIL_A_NORMAL_SETPOINT, regWrData) |=>
      regRdData[LEVEL_MSB:0] == $past(regWrData[LEVEL_MSB:0], 2)
      && regRdData[RANGE_BIT] == rangeSel_reg[RAIL_A])
    else $error("rail A normal set point did not read back");

  // Rail B config round trip
  rail_b_decode_a: assert property (
    wrThenRd(ADDR_RAIL_B_CONFIG, regWrData) |=>
      regRdData == $past(regWrData, 2) && regAck)
    else $error("rail B config did not read back");

  // Bit 7 reads zero on rail A normal and sleep and rail B standby set points
  bit7_zero_a: assert property (
    (regRdEn && (hitNormal[RAIL_A] || hitStandby[RAIL_B]
      || hitSleep[RAIL_A])) |=> !regRdData[7])
    else $error("set point bit 7 read as one");

  // Rail A range bit survives host writes to its normal set point
  range_readonly_a: assert property (
    (!cfgLoad && regWrEn && hitNormal[RAIL_A]) |=>
      $stable(rangeSel_reg[RAIL_A]))
    else $error("host write moved the range bit");

  // Standby and sleep reads report the range bit
  stby_range_a: assert property (
    (regRdEn && hitStandby[RAIL_A]) |=>
      regRdData[RANGE_BIT] == $past(rangeSel_reg[RAIL_A]))
    else $error("standby range bit differs");

  sleep_range_a: assert property (
    (regRdEn && hitSleep[RAIL_B]) |=>
      regRdData[RANGE_BIT] == $past(rangeSel_reg[RAIL_B]))
    else $error("sleep range bit differs");

  // State picks the matching set point one cycle later
  normal_level_a: assert property (
    (opState == OP_NORMAL) |=> railALevelCode ==
      {$past(rangeSel_reg[RAIL_A]), $past(normLvl_reg[RAIL_A])})
    else $error("normal level not applied");

  standby_level_a: assert property (
    (opState == OP_STANDBY) |=> railALevelCode ==
      {$past(rangeSel_reg[RAIL_A]), $past(stbyLvl_reg[RAIL_A])})
    else $error("standby level not applied");

  sleep_level_a: assert property (
    (opState == OP_SLEEP && !singlePhase) |=> railBLevelCode ==
      {$past(rangeSel_reg[RAIL_B]), $past(sleepLvl_reg[RAIL_B])})
    else $error("sleep level not applied");

  // Reserved codes flag invalid and hold the millivolt output
  reserved_hold_a: assert property (
    (selCode[RAIL_A] > CODE_HIGH_MAX) |=>
      !railACodeValid && $stable(railALevelMv))
    else $error("reserved code was applied");

  // Millivolt steps in both ranges
  low_step_a: assert property (
    (!selCode[RAIL_A][RANGE_BIT]) |=> railALevelMv ==
      LOW_BASE_MV + 12'($past(selCode[RAIL_A][LEVEL_MSB:0]) * 25))
    else $error("low range level wrong");

  high_step_a: assert property (
    (selCode[RAIL_A][RANGE_BIT] && selCode[RAIL_A] <= CODE_HIGH_MAX)
      |=> railALevelMv ==
      HIGH_BASE_MV + 12'($past(selCode[RAIL_A][LEVEL_MSB:0]) * 50))
    else $error("high range level wrong");

  low_top_a: assert property (
    (selCode[RAIL_B] == CODE_LOW_MAX && !singlePhase) |=>
      railBLevelMv == 12'd1975 && railBCodeValid)
    else $error("top low code not 1.975 V");

endmodule

// ---- test/bsr_host_model.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Control bus host facing the register bank
// ****************************************************************
module bsr_host_model (
  input wire logic mclk,
  input wire logic regAck,
  input wire logic [7:0] regRdData,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn
);
  // Known idle levels from time zero
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end

  // One access: a single-edge strobe, answer taken at the next edge
  // Extra idle edges let the level outputs settle before the caller looks
  task automatic access(input logic [7:0] addr, input logic [7:0] data,
                        input logic wr, output logic [7:0] rdData,
                        output logic acked);
    @(posedge mclk);
    regAddr <= addr;
    regWrData <= data;
    regWrEn <= wr;
    regRdEn <= !wr;
    @(posedge mclk);
    // Strobe is a pulse: holding it would repeat the access
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    // Released lines show the inverse so stale values never look valid
    regAddr <= ~addr;
    regWrData <= ~data;
    // Answer stands right after the taking edge; sample clear of it
    #1;
    rdData = regRdData;
    acked = (regAck === 1'b1);
    repeat (3) @(posedge mclk);
  endtask

  // Write, then a read of the same address on the very next edge
  task automatic writeRead(input logic [7:0] addr, input logic [7:0] data,
                           output logic [7:0] rdData);
    @(posedge mclk);
    regAddr <= addr;
    regWrData <= data;
    regWrEn <= 1'b1;
    @(posedge mclk);
    // Write taken here; the read follows back to back
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    @(posedge mclk);
    regRdEn <= 1'b0;
    regAddr <= ~addr;
    regWrData <= ~data;
    #1;
    rdData = regRdData;
    repeat (2) @(posedge mclk);
  endtask
endmodule

// ---- test/bsr_setpoint_bank_tb.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Self-checking bench for the set-point register bank
// ****************************************************************
module bsr_setpoint_bank_tb;
  import bsr_pkg::*;
  // Row of the register table: address, write, readback, ack
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdExp;
    logic ackExp;
  } bsr_row_t;
  // Fields stay above 0.6 V and use the low range below 2.0 V
  bsr_row_t rows [0:13] = '{
    '{8'h3C, 8'hE9, 8'h29, 1'b1}, '{8'h3D, 8'h92, 8'h12, 1'b1},
    '{8'h3E, 8'h5B, 8'h1B, 1'b1}, '{8'h3F, 8'hFF, 8'h2F, 1'b1},
    '{8'h40, 8'hA5, 8'hA5, 1'b1}, '{8'h43, 8'hCC, 8'h0C, 1'b1},
    '{8'h44, 8'h3A, 8'h3A, 1'b1}, '{8'h45, 8'h51, 8'h11, 1'b1},
    '{8'h46, 8'hD6, 8'h06, 1'b1}, '{8'h47, 8'h5A, 8'h5A, 1'b1},
    '{8'h3B, 8'h11, 8'h00, 1'b0}, '{8'h41, 8'h22, 8'h00, 1'b0},
    '{8'h42, 8'h33, 8'h00, 1'b0}, '{8'h48, 8'h44, 8'h00, 1'b0}};
  logic mclk, resetn, cfgLoad, singlePhase, regWrEn, regRdEn, regAck;
  logic [1:0] cfgRange;
  bsr_opstate_t opState;
  logic [7:0] regAddr, regWrData, regRdData, rdVal;
  logic [7:0] railAModeOut, railAConfigOut, railBModeOut, railBConfigOut;
  logic [6:0] railALevelCode, railBLevelCode;
  logic [11:0] railALevelMv, railBLevelMv;
  logic railACodeValid, railBCodeValid, railBActive, ackVal;
  int badCount = 0;
  int testsRun = 0;
  int cycles = 0;

  bsr_setpoint_bank dut (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .cfgLoad(cfgLoad), .cfgRange(cfgRange), .opState(opState),
    .singlePhase(singlePhase), .regRdData(regRdData), .regAck(regAck),
    .railALevelCode(railALevelCode), .railALevelMv(railALevelMv),
    .railACodeValid(railACodeValid), .railAModeOut(railAModeOut),
    .railAConfigOut(railAConfigOut), .railBLevelCode(railBLevelCode),
    .railBLevelMv(railBLevelMv), .railBCodeValid(railBCodeValid),
    .railBActive(railBActive), .railBModeOut(railBModeOut),
    .railBConfigOut(railBConfigOut));

  bsr_host_model host (.mclk(mclk), .regAck(regAck), .regRdData(regRdData),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn));

  // ****************************************************************
  // Clock, timeout and reporting
  // ****************************************************************
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      badCount++;
      finalReport();
    end
  end

  task automatic finalReport();
    if (badCount == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Register data and handshake results
  task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Applied level results: code, millivolts or valid flag
  task automatic chkLvl(input logic [11:0] got, input logic [11:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Millivolts for a field in each range
  function automatic logic [11:0] lowMv(input logic [5:0] f);
    return 12'h190 + 12'h019 * {6'h00, f};
  endfunction
  function automatic logic [11:0] highMv(input logic [5:0] f);
    return 12'h320 + 12'h032 * {6'h00, f};
  endfunction

  // ****************************************************************
  // Stimulus helpers
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(a, d, 1'b1, rdVal, ackVal);
  endtask
  task automatic rd(input logic [7:0] a);
    host.access(a, 8'h00, 1'b0, rdVal, ackVal);
  endtask

  // Both rails' applied levels, sampled clear of the edge
  task automatic lvl(input logic [6:0] cA, input logic [11:0] mA,
                     input logic vA, input logic [6:0] cB,
                     input logic [11:0] mB, input logic vB);
    #1;
    chkLvl({5'h00, railALevelCode}, {5'h00, cA});
    chkLvl(railALevelMv, mA);
    chkLvl({11'h000, railACodeValid}, {11'h000, vA});
    chkLvl({5'h00, railBLevelCode}, {5'h00, cB});
    chkLvl(railBLevelMv, mB);
    chkLvl({11'h000, railBCodeValid}, {11'h000, vB});
  endtask

  // Reset held seven cycles, outputs checked while it is held
  task automatic doReset();
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    chkReg({7'h00, regAck}, 8'h00);
    lvl(7'h00, 12'h190, 1'b1, 7'h00, 12'h190, 1'b1);
    @(posedge mclk);
    resetn <= 1'b1;
  endtask

  task automatic setState(input bsr_opstate_t s);
    @(posedge mclk);
    opState <= s;
    repeat (2) @(posedge mclk);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    resetn = 1'b0;
    cfgLoad = 1'b0;
    cfgRange = 2'b00;
    opState = OP_NORMAL;
    singlePhase = 1'b0;
    doReset();
    // Table rows: zero after reset, write, then read back
    foreach (rows[i]) begin
      rd(rows[i].addr);
      chkReg(rdVal, 8'h00);
      wr(rows[i].addr, rows[i].wrData);
      chkReg({7'h00, ackVal}, {7'h00, rows[i].ackExp});
      rd(rows[i].addr);
      chkReg({7'h00, ackVal}, {7'h00, rows[i].ackExp});
      chkReg(rdVal, rows[i].rdExp);
    end
    #1;
    chkReg(railAModeOut, 8'h2F);
    chkReg(railBConfigOut, 8'h5A);
    chkReg(railAConfigOut, 8'hA5);
    chkReg(railBModeOut, 8'h06);
    lvl(7'h29, lowMv(6'h29), 1'b1, 7'h0C, lowMv(6'h0C), 1'b1);
    setState(OP_STANDBY);
    lvl(7'h12, lowMv(6'h12), 1'b1, 7'h3A, lowMv(6'h3A), 1'b1);
    setState(OP_SLEEP);
    lvl(7'h1B, lowMv(6'h1B), 1'b1, 7'h11, lowMv(6'h11), 1'b1);
    setState(OP_NORMAL);
    // Top of the low range on rail B
    wr(8'h43, 8'h3F);
    lvl(7'h29, lowMv(6'h29), 1'b1, 7'h3F, 12'h7B7, 1'b1);
    // Configuration load sets rail A to the high range only
    @(posedge mclk);
    cfgLoad <= 1'b1;
    cfgRange <= 2'b01;
    @(posedge mclk);
    cfgLoad <= 1'b0;
    wr(8'h3C, 8'h32);
    rd(8'h3C);
    chkReg(rdVal, 8'h72);
    rd(8'h3D);
    chkReg(rdVal, 8'h52);
    rd(8'h3E);
    chkReg(rdVal, 8'h5B);
    rd(8'h43);
    chkReg(rdVal, 8'h3F);
    lvl(7'h72, 12'hCE4, 1'b1, 7'h3F, 12'h7B7, 1'b1);
    // First reserved code: flagged, level held
    wr(8'h3C, 8'h33);
    lvl(7'h73, 12'hCE4, 1'b0, 7'h3F, 12'h7B7, 1'b1);
    // Combined output: rail B forced off, rail A still follows
    @(posedge mclk);
    singlePhase <= 1'b1;
    wr(8'h3C, 8'h20);
    #1;
    chkReg({7'h00, railBActive}, 8'h00);
    lvl(7'h60, highMv(6'h20), 1'b1, 7'h00, 12'h190, 1'b0);
    @(posedge mclk);
    singlePhase <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chkReg({7'h00, railBActive}, 8'h01);
    // Back-to-back write and read; rail A is in the high range, 2.0 V
    host.writeRead(8'h3C, 8'h98, rdVal);
    chkReg(rdVal, 8'h58);
    host.writeRead(8'h47, 8'hC3, rdVal);
    chkReg(rdVal, 8'hC3);
    // Second reset in mid-run clears fields and range
    doReset();
    rd(8'h3C);
    chkReg(rdVal, 8'h00);
    rd(8'h45);
    chkReg(rdVal, 8'h00);
    finalReport();
  end
endmodule
